// File: core/mdio_frame.sv
// Purpose: shifts one management frame out and samples turnaround and read data
// Assumes: mdc_rise_i marks a synchronised rising edge of the link clock
// Notes:   output changes after a rising edge, input sampled at the next one
`timescale 1ns/1ps
`include "mdio_user_consts.svh"
module mdio_frame
	import mdio_user_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        mdc_rise_i,
	input  wire logic        start_i,
	input  wire logic        write_i,
	input  wire logic [4:0]  phy_i,
	input  wire logic [4:0]  reg_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        mdio_in_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	output logic             busy_o,
	output logic             done_o,
	output logic             ack_o,
	output logic [15:0]      rdata_o
);

	eng_state_t  state_r;
	logic [63:0] shift_r;
	logic [6:0]  bit_r;
	logic        wr_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r   <= ENG_IDLE;
			shift_r   <= '0;
			bit_r     <= '0;
			wr_r      <= 1'b0;
			mdio_o    <= 1'b0;
			mdio_oe_o <= 1'b0;
			done_o    <= 1'b0;
			ack_o     <= 1'b0;
			rdata_o   <= '0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				ENG_IDLE: begin
					if (start_i) begin
						shift_r <= {`FRAME_PREAMBLE, `FRAME_START,
							write_i ? `FRAME_OP_WRITE : `FRAME_OP_READ,
							phy_i, reg_i, `FRAME_TA_WRITE, wdata_i};
						wr_r    <= write_i;
						bit_r   <= '0;
						state_r <= ENG_RUN;
					end
				end
				ENG_RUN: begin
					if (mdc_rise_i) begin
						// bit_r-1 has just been sampled by the far end
						if (!wr_r && bit_r == `FRAME_ACK_BIT + 7'h1)
							ack_o <= ~mdio_in_i;
						if (!wr_r && bit_r > `FRAME_ACK_BIT + 7'h1)
							rdata_o <= {rdata_o[14:0], mdio_in_i};
						if (bit_r == `FRAME_BITS) begin
							mdio_oe_o <= 1'b0;
							state_r   <= ENG_FIN;
						end else begin
							mdio_o    <= shift_r[63];
							mdio_oe_o <= wr_r || bit_r < `FRAME_TA_FIRST;
							shift_r   <= {shift_r[62:0], 1'b0};
							bit_r     <= bit_r + 7'h1;
						end
					end
				end
				ENG_FIN: begin
					done_o  <= 1'b1;
					state_r <= ENG_IDLE;
				end
				default: state_r <= ENG_IDLE;
			endcase
		end
	end

	assign busy_o = (state_r != ENG_IDLE);

endmodule : mdio_frame

// File: core/mdio_user_command_access.sv
// Purpose: software side of the management user command slot and its interrupts
// Assumes: classic Wishbone slave, link clock sampled as a plain input
// Notes:   slot 1 completion arrives as a pulse from neighbouring logic
// Operation
// - writing one to disable bit turns slot off
// - writing zero to disable bit changes nothing
// - disable read shows one per disabled slot
// - go one schedules one management access later
// - go zero never cancels an access
// - go accepted only while state machine enabled
// - go self-clears when access completes
// - go high blocks all slot writes
// - write bit selects phy write or read
// - ack bit set when phy acknowledged read
// - register index field drives frame register
// - phy select field drives frame address
// - data sent on write, loaded on read
// - bits 28 to 26 read zero
// - enable register one bits enable slots
// - masked status reads event and enable, w1c
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "mdio_user_consts.svh"
module mdio_user_command_access
	import mdio_user_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sm_enable_i,
	input  wire logic        slot1_done_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	output logic             irq_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	function automatic logic hit(input logic [5:0] adr, input logic [5:0] ofs);
		hit = (adr[5:2] == ofs[5:2]);
	endfunction : hit

	// ----------------------------------------
	// pin synchronisers and link clock edge
	// ----------------------------------------
	logic [1:0] pins_s;
	logic       mdc_d_r;
	logic       mdc_rise;

	sync2 #(
		.WIDTH (2)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({mdc_i, mdio_i}),
		.q_o   (pins_s)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) mdc_d_r <= 1'b0;
		else       mdc_d_r <= pins_s[1];
	end

	assign mdc_rise = pins_s[1] & ~mdc_d_r;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic        req;
	logic        wr_req;
	logic [31:0] wmask;
	logic [31:0] wdat;

	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_req = req & wb_we_i;
	assign wmask  = lane_mask(wb_sel_i);
	assign wdat   = wb_dat_i & wmask;

	// ----------------------------------------
	// command slot 0
	// ----------------------------------------
	logic        go_r;
	logic        dir_r;
	logic        ack_r;
	logic [4:0]  reg_idx_r;
	logic [4:0]  phy_idx_r;
	logic [15:0] data_r;
	logic        launched_r;
	logic [31:0] slot0_view;
	logic [31:0] slot0_nxt;
	logic        slot0_wr;
	logic        eng_busy;
	logic        eng_done;
	logic        eng_ack;
	logic [15:0] eng_rdata;
	logic        eng_start;

	assign slot0_view = {go_r, dir_r, ack_r, 3'h0, reg_idx_r, phy_idx_r, data_r};
	assign slot0_nxt  = (slot0_view & ~wmask) | wdat;
	assign slot0_wr   = wr_req & hit(wb_adr_i, `OFS_PHY_CMD_SLOT0) & ~go_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			go_r <= 1'(`RST_PHY_CMD_SLOT0 >> `CMD_GO_BIT);
		end else if (eng_done && launched_r) begin
			go_r <= 1'b0;
		end else if (slot0_wr && sm_enable_i && wb_sel_i[3] && wb_dat_i[`CMD_GO_BIT]) begin
			go_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_r     <= 1'b0;
			reg_idx_r <= '0;
			phy_idx_r <= '0;
		end else if (slot0_wr) begin
			dir_r     <= slot0_nxt[`CMD_WRITE_BIT];
			reg_idx_r <= slot0_nxt[`CMD_REG_MSB:`CMD_REG_LSB];
			phy_idx_r <= slot0_nxt[`CMD_PHY_MSB:`CMD_PHY_LSB];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			data_r <= '0;
		end else if (eng_done && launched_r && !dir_r) begin
			ack_r  <= eng_ack;
			data_r <= eng_rdata;
		end else if (slot0_wr) begin
			ack_r  <= slot0_nxt[`CMD_ACK_BIT];
			data_r <= slot0_nxt[`CMD_DATA_MSB:`CMD_DATA_LSB];
		end
	end

	// ----------------------------------------
	// launch of the queued access
	// ----------------------------------------
	assign eng_start = go_r & ~launched_r & ~eng_busy;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)              launched_r <= 1'b0;
		else if (eng_start)     launched_r <= 1'b1;
		else if (eng_done)      launched_r <= 1'b0;
	end

	mdio_frame u_frame (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.mdc_rise_i (mdc_rise),
		.start_i    (eng_start),
		.write_i    (dir_r),
		.phy_i      (phy_idx_r),
		.reg_i      (reg_idx_r),
		.wdata_i    (data_r),
		.mdio_in_i  (pins_s[0]),
		.mdio_o     (mdio_o),
		.mdio_oe_o  (mdio_oe_o),
		.busy_o     (eng_busy),
		.done_o     (eng_done),
		.ack_o      (eng_ack),
		.rdata_o    (eng_rdata)
	);

	// ----------------------------------------
	// completion events and interrupt enables
	// ----------------------------------------
	slot_bits_t irq_en_r;
	slot_bits_t raw_r;
	slot_bits_t raw_set;
	slot_bits_t masked;

	assign raw_set = {slot1_done_i, eng_done & launched_r};
	assign masked  = raw_r & irq_en_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_en_r <= `RST_IRQ_ENABLE;
		end else if (wr_req && wb_sel_i[0]) begin
			if (hit(wb_adr_i, `OFS_CMD_DONE_IRQ_DISABLE))
				irq_en_r <= irq_en_r & ~wb_dat_i[1:0];
			else if (hit(wb_adr_i, `OFS_CMD_DONE_IRQ_ENABLE))
				irq_en_r <= irq_en_r | wb_dat_i[1:0];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			raw_r <= `RST_RAW_STATUS;
		end else if (wr_req && wb_sel_i[0] && hit(wb_adr_i, `OFS_CMD_DONE_MASKED_STATUS)) begin
			raw_r <= (raw_r & ~(wb_dat_i[1:0] & irq_en_r)) | raw_set;
		end else if (wr_req && wb_sel_i[0] && hit(wb_adr_i, `OFS_CMD_DONE_RAW_STATUS)) begin
			raw_r <= (raw_r & ~wb_dat_i[1:0]) | raw_set;
		end else begin
			raw_r <= raw_r | raw_set;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) irq_o <= 1'b0;
		else       irq_o <= |masked;
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(wb_adr_i, `OFS_PHY_CMD_SLOT0))
			rd_mux = slot0_view;
		else if (hit(wb_adr_i, `OFS_CMD_DONE_IRQ_DISABLE))
			rd_mux = {30'h0, ~irq_en_r};
		else if (hit(wb_adr_i, `OFS_CMD_DONE_IRQ_ENABLE))
			rd_mux = {30'h0, irq_en_r};
		else if (hit(wb_adr_i, `OFS_CMD_DONE_MASKED_STATUS))
			rd_mux = {30'h0, masked};
		else if (hit(wb_adr_i, `OFS_CMD_DONE_RAW_STATUS))
			rd_mux = {30'h0, raw_r};
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
		end
	end

endmodule : mdio_user_command_access

// File: core/mdio_user_consts.svh
// Purpose: offsets, field positions, reset values and frame counts of the user command block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   definitions only
`ifndef MDIO_USER_CONSTS_SVH
`define MDIO_USER_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_PHY_CMD_SLOT0          6'h00
`define OFS_CMD_DONE_IRQ_DISABLE   6'h04
`define OFS_CMD_DONE_IRQ_ENABLE    6'h08
`define OFS_CMD_DONE_MASKED_STATUS 6'h0C
`define OFS_CMD_DONE_RAW_STATUS    6'h10

// ----------------------------------------
// phy_cmd_slot0 fields
// ----------------------------------------
`define CMD_GO_BIT      31
`define CMD_WRITE_BIT   30
`define CMD_ACK_BIT     29
`define CMD_REG_MSB     25
`define CMD_REG_LSB     21
`define CMD_PHY_MSB     20
`define CMD_PHY_LSB     16
`define CMD_DATA_MSB    15
`define CMD_DATA_LSB    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PHY_CMD_SLOT0 32'h0000_0000
`define RST_IRQ_ENABLE    2'h0
`define RST_RAW_STATUS    2'h0

// ----------------------------------------
// management frame
// ----------------------------------------
`define FRAME_BITS      7'h40
`define FRAME_PREAMBLE  32'hFFFF_FFFF
`define FRAME_START     2'h1
`define FRAME_OP_WRITE  2'h1
`define FRAME_OP_READ   2'h2
`define FRAME_TA_WRITE  2'h2
`define FRAME_TA_FIRST  7'h2E
`define FRAME_ACK_BIT   7'h2F

`endif

// File: core/mdio_user_pkg.sv
// Purpose: types shared by the user command block
// Assumes: nothing
// Notes:   gray-coded frame engine states
package mdio_user_pkg;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'h0,
		ENG_RUN  = 2'h1,
		ENG_FIN  = 2'h3
	} eng_state_t;

	typedef logic [1:0] slot_bits_t;

endpackage : mdio_user_pkg

// File: core/sync2.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;

	initial begin
		if (WIDTH < 1) $error("sync2: WIDTH must be at least 1");
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule : sync2

// File: tb/mua_props.sv
// Purpose: bus and interrupt checks
// Assumes: en_r mirrors the enable register
// Notes:   bound to the top module
`timescale 1ns/1ps
module mua_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        slot1_done_i,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic [1:0]      en_r;
	wire logic       wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	wire logic       rd = wb_ack_o & ~wb_we_i;
	wire logic [3:0] wa = wb_adr_i[5:2];
	// ----
	// enable mirror
	// ----
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			en_r <= 2'h0;
		else if (wr && wa == 4'h1)
			en_r <= en_r & ~wb_dat_i[1:0];
		else if (wr && wa == 4'h2)
			en_r <= en_r | wb_dat_i[1:0];
	end
	AST_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data outside ack");
	AST_RSVD: assert property (rd && wa == 4'h0 |-> wb_dat_o[28:26] == 3'h0)
		else $error("reserved bits set");
	AST_DIS: assert property (rd && wa == 4'h1 |-> wb_dat_o == {30'h0, ~en_r})
		else $error("disable read wrong");
	AST_EN: assert property (rd && wa == 4'h2 |-> wb_dat_o == {30'h0, en_r})
		else $error("enable read wrong");
	AST_MASK: assert property (rd && wa == 4'h3 |-> (wb_dat_o & ~{30'h0, en_r}) == 32'h0)
		else $error("masked status wrong");
	AST_IRQ: assert property (irq_o |-> (en_r | $past(en_r)) != 2'h0)
		else $error("irq while disabled");
	AST_SLOT1: assert property (slot1_done_i && en_r[1] ##1 en_r[1] |=> irq_o)
		else $error("slot 1 irq missing");
	CV_IRQ: cover property ($rose(irq_o));
	CV_DIS: cover property (rd && wa == 4'h1);
	CV_SLOT1: cover property (slot1_done_i && en_r[1]);
endmodule : mua_props

bind mdio_user_command_access mua_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slot1_done_i(slot1_done_i), .irq_o(irq_o)
);

// File: tb/phy_model.sv
// Purpose: phy at the far end of the link
// Assumes: pull-up on the data line
// Notes:   link clock runs only while run_i is high
`timescale 1ns/1ps
module phy_model (
	input wire logic        run_i,
	input wire logic        nak_i,
	input wire logic [15:0] rdata_i,
	input wire logic        pin_i,
	output logic            mdc_o,
	output logic            drv_o,
	output logic            val_o,
	output logic [29:0]     frm_o
);
	int   pos;
	logic rd_r;
	initial begin
		mdc_o = 1'b0;
		drv_o = 1'b0;
		val_o = 1'b1;
		frm_o = 30'h0;
		pos = -1;
		rd_r = 1'b0;
		#37;
		forever #400 mdc_o = run_i ? ~mdc_o : 1'b0;
	end
	// ----
	// first zero on the line is start bit 32
	// ----
	always @(posedge mdc_o) begin
		if (pos < 0)
			pos = pin_i ? -1 : 32;
		else
			pos = (pos == 63) ? -1 : pos + 1;
		if (pos >= 34)
			frm_o = {frm_o[28:0], pin_i};
		if (pos == 35)
			rd_r = (frm_o[1:0] == 2'h2);
	end
	// drive the next bit mid-window, hold across the sampling rise
	always @(negedge mdc_o) begin
		drv_o = 1'b0;
		if (rd_r && pos == 46 && !nak_i) begin
			drv_o = 1'b1;
			val_o = 1'b0;
		end else if (rd_r && pos >= 47 && pos < 63) begin
			drv_o = 1'b1;
			val_o = rdata_i[62-pos];
		end
	end
endmodule : phy_model

// File: tb/tb.sv
// Purpose: scenarios for the command block
// Assumes: phy_model on the link
// Notes:   link clock runs only during frames
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic        sm_en = 1'b0;
	logic        s1 = 1'b0;
	logic        run = 1'b0;
	logic        nak = 1'b0;
	logic [15:0] rdv = 16'h0;
	logic [31:0] rdat;
	logic        ack, mdc, mo, moe, irq, drv, val;
	logic [29:0] frm;
	wire logic   pin = moe ? mo : (drv ? val : 1'b1);
	int          miscompares = 0;
	int          tests_run = 0;
	mdio_user_command_access dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sm_enable_i(sm_en),
		.slot1_done_i(s1), .mdc_i(mdc), .mdio_i(pin), .mdio_o(mo),
		.mdio_oe_o(moe), .irq_o(irq)
	);
	phy_model phy (
		.run_i(run), .nak_i(nak), .rdata_i(rdv), .pin_i(pin),
		.mdc_o(mdc), .drv_o(drv), .val_o(val), .frm_o(frm)
	);
	initial forever #50 clk_i = ~clk_i;
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
			miscompares++;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc
	task automatic ic(input logic e);
		@(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask : ic
	// polls go until it clears while the link clock runs
	task automatic frame;
		logic [31:0] q;
		int n;
		n = 0;
		run <= 1'b1;
		do begin
			bus(1'b0, 6'h00, 32'h0, q);
			n++;
		end while (q[31] !== 1'b0 && n < 400);
		run <= 1'b0;
		chk({31'h0, q[31]}, 32'h0);
	endtask : frame
	task automatic pulse;
		s1 <= 1'b1;
		@(posedge clk_i);
		s1 <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : pulse
	task automatic end_sim;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	// ----
	// scenarios
	// ----
	task automatic s_reset;
		rc(6'h00, 32'h0);
		rc(6'h04, 32'h3);
		rc(6'h08, 32'h0);
		rc(6'h0C, 32'h0);
		rc(6'h14, 32'h0);
		ic(1'b0);
	endtask : s_reset
	task automatic s_mask;
		wr(6'h08, 32'h3);
		rc(6'h04, 32'h0);
		wr(6'h04, 32'h0);
		rc(6'h08, 32'h3);
		wr(6'h04, 32'h2);
		rc(6'h04, 32'h2);
		wr(6'h14, 32'hFFFFFFFF);
		rc(6'h08, 32'h1);
	endtask : s_mask
	task automatic s_slot1;
		pulse;
		rc(6'h0C, 32'h0);
		rc(6'h10, 32'h2);
		ic(1'b0);
		wr(6'h08, 32'h2);
		rc(6'h0C, 32'h2);
		ic(1'b1);
		wr(6'h0C, 32'h2);
		rc(6'h10, 32'h0);
		pulse;
		ic(1'b1);
		wr(6'h10, 32'h2);
		ic(1'b0);
	endtask : s_slot1
	task automatic s_write;
		wr(6'h00, 32'hDEAAA5C3);
		rc(6'h00, 32'h42AAA5C3);
		sm_en <= 1'b1;
		wr(6'h00, 32'hDEAAA5C3);
		rc(6'h00, 32'hC2AAA5C3);
		wr(6'h00, 32'h00000000);
		rc(6'h00, 32'hC2AAA5C3);
		frame;
		chk({2'h0, frm}, {2'h0, 2'h1, 5'h0A, 5'h15, 2'h2, 16'hA5C3});
		rc(6'h00, 32'h42AAA5C3);
		rc(6'h0C, 32'h1);
		ic(1'b1);
		wr(6'h0C, 32'h1);
		rc(6'h10, 32'h0);
		ic(1'b0);
	endtask : s_write
	task automatic s_read;
		wr(6'h04, 32'h1);
		rdv <= 16'h3C96;
		wr(6'h00, 32'h83FF0000);
		frame;
		chk({20'h0, frm[29:18]}, 32'hBFF);
		rc(6'h00, 32'h23FF3C96);
		rc(6'h10, 32'h1);
		rc(6'h0C, 32'h0);
		ic(1'b0);
		nak <= 1'b1;
		rdv <= 16'h0F0F;
		wr(6'h00, 32'h83FF0000);
		frame;
		rc(6'h00, 32'h03FF0F0F);
	endtask : s_read
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		s_reset;
		s_mask;
		s_slot1;
		s_write;
		s_read;
		end_sim;
	end
	initial begin
		#2000000;
		miscompares++;
		end_sim;
	end
endmodule : tb
